// *** rtl/ivf_input_voltage_fault.sv ***
`timescale 1ns/1ns
`default_nettype none
module ivf_input_voltage_fault #(
  parameter int P_MS_CYCLES = ivf_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // command port
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  output logic [15:0] o_cmd_rdata,
  output logic o_cmd_ack,
  output logic o_cmd_nack,
  // measured input voltage
  input wire logic [15:0] i_vin_linear,
  input wire logic i_vin_valid,
  // converter control
  input wire logic i_on_cmd,
  input wire logic i_bias_ok,
  input wire logic i_clear_faults,
  input wire logic i_clear_uv_fault_bit,
  input wire logic i_other_shutdown,
  input wire logic i_ratio_regulation_en,
  input wire logic [7:0] i_time_unit_ms,
  // status and power stage
  output logic o_output_enable,
  output logic o_vin_ov_warn,
  output logic o_vin_uv_warn,
  output logic o_vin_uv_fault,
  output logic o_ratio_regulation_active,
  output logic o_latched_off,
  output logic [2:0] o_retry_count
);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_DELAY_ON,
    ST_WAIT_RETRY,
    ST_LATCHED
  } ivf_state_t;

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic [15:0] ov_warn_r;
  logic [15:0] uv_warn_r;
  logic [15:0] uv_fault_r;
  logic [7:0] uv_action_r;

  // command code decode
  wire hit_ov = (i_cmd_code == ivf_pkg::CMD_VIN_OV_WARN);
  wire hit_uvw = (i_cmd_code == ivf_pkg::CMD_VIN_UV_WARN);
  wire hit_uvf = (i_cmd_code == ivf_pkg::CMD_VIN_UV_FAULT);
  wire hit_act = (i_cmd_code == ivf_pkg::CMD_VIN_UV_ACTION);
  wire hit_any = hit_ov | hit_uvw | hit_uvf | hit_act;

  // read data selection, unknown codes read zero
  wire [15:0] rd_sel = hit_ov ? ov_warn_r :
                       hit_uvw ? uv_warn_r :
                       hit_uvf ? uv_fault_r :
                       hit_act ? {8'h00, uv_action_r} : 16'h0000;

  // setting writes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ov_warn_r <= ivf_pkg::RST_OV_WARN;
      uv_warn_r <= ivf_pkg::RST_UV_WARN;
      uv_fault_r <= ivf_pkg::RST_UV_FAULT;
      uv_action_r <= ivf_pkg::RST_UV_ACTION;
    end else if (i_cmd_wr) begin
      if (hit_ov) ov_warn_r <= i_cmd_wdata;
      if (hit_uvw) uv_warn_r <= i_cmd_wdata;
      if (hit_uvf) uv_fault_r <= i_cmd_wdata;
      if (hit_act) uv_action_r <= i_cmd_wdata[7:0];
    end
  end

  // command answer, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_cmd_rdata <= 16'h0000;
      o_cmd_ack <= 1'b0;
      o_cmd_nack <= 1'b0;
    end else begin
      if (i_cmd_rd) o_cmd_rdata <= rd_sel;
      o_cmd_ack <= (i_cmd_wr | i_cmd_rd) & hit_any;
      o_cmd_nack <= (i_cmd_wr | i_cmd_rd) & ~hit_any;
    end
  end

  // ---------------------------------------------------------------
  // threshold comparison
  // ---------------------------------------------------------------
  wire signed [ivf_pkg::FIX_W-1:0] vin_fix =
    ivf_pkg::lin_to_fix(i_vin_linear);
  wire signed [ivf_pkg::FIX_W-1:0] ov_fix = ivf_pkg::lin_to_fix(ov_warn_r);
  wire signed [ivf_pkg::FIX_W-1:0] uvw_fix = ivf_pkg::lin_to_fix(uv_warn_r);
  wire signed [ivf_pkg::FIX_W-1:0] uvf_fix = ivf_pkg::lin_to_fix(uv_fault_r);

  logic uv_fault_now_r;

  // compare each new sample against the thresholds
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_vin_ov_warn <= 1'b0;
      o_vin_uv_warn <= 1'b0;
      uv_fault_now_r <= 1'b0;
      o_ratio_regulation_active <= 1'b0;
    end else if (i_vin_valid) begin
      o_vin_ov_warn <= vin_fix > ov_fix;
      o_vin_uv_warn <= vin_fix < uvw_fix;
      uv_fault_now_r <= vin_fix < uvf_fix;
      o_ratio_regulation_active <= i_ratio_regulation_en &
                                   (vin_fix >= uvw_fix);
    end else if (!i_ratio_regulation_en) begin
      o_ratio_regulation_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // action byte decode
  // ---------------------------------------------------------------
  wire [1:0] resp = uv_action_r[ivf_pkg::RESP_MSB:ivf_pkg::RESP_LSB];
  wire [2:0] retries = uv_action_r[ivf_pkg::RETRY_MSB:ivf_pkg::RETRY_LSB];
  wire [2:0] delay_code = uv_action_r[ivf_pkg::DELAY_MSB:ivf_pkg::DELAY_LSB];
  wire [7:0] delay_len = ivf_pkg::delay_units(delay_code);

  // ---------------------------------------------------------------
  // delay timer in time units
  // ---------------------------------------------------------------
  logic timer_start;
  logic unit_tick;
  logic [7:0] units_r;
  wire timer_done = unit_tick && (units_r == delay_len - 8'h01);

  ivf_unit_tick #(
    .P_MS_CYCLES(P_MS_CYCLES)
  ) u_unit_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_restart(timer_start),
    .i_unit_ms(i_time_unit_ms),
    .o_tick(unit_tick)
  );

  // count elapsed units since the timer was started
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || timer_start) begin
      units_r <= 8'h00;
    end else if (unit_tick) begin
      units_r <= units_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // fault flag and clearing
  // ---------------------------------------------------------------
  logic fault_flag_r;
  logic on_cmd_d_r;
  wire on_rise = i_on_cmd & ~on_cmd_d_r;
  wire clear_evt = i_clear_faults | i_clear_uv_fault_bit | on_rise;

  // sticky fault flag, a new fault wins over a clear
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_bias_ok) begin
      fault_flag_r <= 1'b0;
      on_cmd_d_r <= 1'b0;
    end else begin
      on_cmd_d_r <= i_on_cmd;
      if (uv_fault_now_r) begin
        fault_flag_r <= 1'b1;
      end else if (clear_evt) begin
        fault_flag_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // response state machine
  // ---------------------------------------------------------------
  ivf_state_t state_r;
  ivf_state_t state_nxt;
  logic [2:0] tries_r;
  logic [2:0] tries_nxt;
  wire [2:0] tries_inc = tries_r + 3'h1;
  wire no_retry = (retries == ivf_pkg::RETRY_NONE);
  // unlimited retries never run out of attempts
  wire retry_unlimited = (retries == ivf_pkg::RETRY_FOREVER);
  wire out_of_tries = !retry_unlimited && (tries_inc >= retries);

  // next state, attempt count and timer start
  always_comb begin
    state_nxt = state_r;
    tries_nxt = tries_r;
    timer_start = 1'b0;
    if (!i_bias_ok || !i_on_cmd) begin
      state_nxt = ST_OFF;
      tries_nxt = 3'h0;
    end else if (i_other_shutdown && state_r != ST_OFF) begin
      state_nxt = ST_LATCHED;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_RUN;
          tries_nxt = 3'h0;
        end
        ST_RUN: begin
          if (uv_fault_now_r) begin
            case (resp)
              ivf_pkg::RESP_IGNORE: state_nxt = ST_RUN;
              ivf_pkg::RESP_DELAY_ON: begin
                state_nxt = ST_DELAY_ON;
                timer_start = 1'b1;
              end
              ivf_pkg::RESP_DISABLE_RETRY: begin
                if (no_retry) begin
                  state_nxt = ST_LATCHED;
                end else begin
                  state_nxt = ST_WAIT_RETRY;
                  timer_start = 1'b1;
                end
              end
              default: state_nxt = ST_LATCHED;
            endcase
          end
        end
        ST_DELAY_ON: begin
          if (!uv_fault_now_r) begin
            state_nxt = ST_RUN;
          end else if (timer_done) begin
            if (no_retry) begin
              state_nxt = ST_LATCHED;
            end else begin
              state_nxt = ST_WAIT_RETRY;
              timer_start = 1'b1;
            end
          end
        end
        ST_WAIT_RETRY: begin
          if (timer_done) begin
            if (!uv_fault_now_r) begin
              state_nxt = ST_RUN;
              tries_nxt = 3'h0;
            end else if (out_of_tries) begin
              state_nxt = ST_LATCHED;
              tries_nxt = tries_inc;
            end else begin
              tries_nxt = retry_unlimited ? tries_r : tries_inc;
              timer_start = 1'b1;
            end
          end
        end
        ST_LATCHED: begin
          if (clear_evt) begin
            state_nxt = ST_RUN;
            tries_nxt = 3'h0;
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  // state and registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= ST_OFF;
      tries_r <= 3'h0;
      o_output_enable <= 1'b0;
      o_latched_off <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tries_r <= tries_nxt;
      o_output_enable <= (state_nxt == ST_RUN) ||
                         (state_nxt == ST_DELAY_ON);
      o_latched_off <= (state_nxt == ST_LATCHED);
    end
  end

  assign o_vin_uv_fault = fault_flag_r;
  assign o_retry_count = tries_r;

endmodule
`default_nettype wire

// *** rtl/ivf_pkg.sv ***
package ivf_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_ACTION = 8'h5a;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_OV_WARN = 16'h0000;
  localparam logic [15:0] RST_UV_WARN = 16'h0000;
  localparam logic [15:0] RST_UV_FAULT = 16'h0000;
  localparam logic [7:0] RST_UV_ACTION = 8'h00;

  // ---------------------------------------------------------------
  // action byte fields
  // ---------------------------------------------------------------
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY_ON = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ---------------------------------------------------------------
  // linear format fields
  // ---------------------------------------------------------------
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;
  localparam int LIN_FRAC_BITS = 16;
  localparam int FIX_W = 48;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  // linear (5-bit exponent, 11-bit mantissa) to fixed point
  function automatic logic signed [FIX_W-1:0] lin_to_fix(
    input logic [15:0] lin
  );
    logic signed [FIX_W-1:0] mant;
    logic signed [5:0] sh;
    mant = FIX_W'(signed'(lin[LIN_MANT_MSB:0]));
    sh = 6'(signed'(lin[LIN_EXP_MSB:LIN_EXP_LSB])) + 6'(LIN_FRAC_BITS);
    return mant <<< sh[4:0];
  endfunction

  // delay code n to 2**n time units
  function automatic logic [7:0] delay_units(input logic [2:0] n);
    return 8'h01 << n;
  endfunction

endpackage

// *** rtl/ivf_unit_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
module ivf_unit_tick #(
  parameter int P_MS_CYCLES = ivf_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_restart,
  input wire logic [7:0] i_unit_ms,
  // tick
  output logic o_tick
);

  logic [15:0] cyc_r;
  logic [7:0] ms_r;
  wire ms_end = (cyc_r == 16'(P_MS_CYCLES - 1));
  wire [7:0] unit_last = (i_unit_ms == 8'h00) ? 8'h00 : i_unit_ms - 8'h01;
  wire unit_end = ms_end && (ms_r >= unit_last);

  // millisecond divider and unit counter, restartable
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_restart) begin
      cyc_r <= 16'h0000;
      ms_r <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      cyc_r <= ms_end ? 16'h0000 : cyc_r + 16'h0001;
      if (unit_end) begin
        ms_r <= 8'h00;
      end else if (ms_end) begin
        ms_r <= ms_r + 8'h01;
      end
      o_tick <= unit_end;
    end
  end

endmodule
`default_nettype wire

// *** verification/ivf_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module ivf_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // command port
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic o_cmd_ack,
  input wire logic o_cmd_nack,
  // control and status
  input wire logic i_on_cmd,
  input wire logic i_bias_ok,
  input wire logic i_clear_faults,
  input wire logic i_clear_uv_fault_bit,
  input wire logic i_other_shutdown,
  input wire logic i_ratio_regulation_en,
  input wire logic o_output_enable,
  input wire logic o_vin_uv_fault,
  input wire logic o_ratio_regulation_active,
  input wire logic o_latched_off,
  input wire logic [2:0] o_retry_count
);
  // ----
  // shadow of the action byte
  // ----
  logic [7:0] act_r;
  logic [7:0] act_nxt;
  wire logic mapped = i_cmd_code >= ivf_pkg::CMD_VIN_OV_WARN &&
    i_cmd_code <= ivf_pkg::CMD_VIN_UV_ACTION;
  wire logic [1:0] resp = act_r[7:6];
  wire logic run_ok = i_on_cmd && i_bias_ok && !i_other_shutdown;
  assign act_nxt = (i_cmd_wr && i_cmd_code == ivf_pkg::CMD_VIN_UV_ACTION) ?
    i_cmd_wdata[7:0] : act_r;
  // action register follows writes
  always_ff @(posedge i_clk) begin
    act_r <= i_reset_n ? act_nxt : 8'h00;
  end

  // ----
  // properties
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_cmd_mapped;
    (i_cmd_wr || i_cmd_rd) && mapped;
  endsequence
  sequence s_fault_on(logic [1:0] r);
    $rose(o_vin_uv_fault) && resp == r;
  endsequence

  a_cmd_ack_mapped: assert property (
    s_cmd_mapped |=> o_cmd_ack && !o_cmd_nack)
    else $error("mapped command not acknowledged");
  a_cmd_nack_unmapped: assert property (
    i_cmd_rd && !mapped |=>
    o_cmd_nack && !o_cmd_ack && o_cmd_rdata == 16'h0000)
    else $error("unmapped read not refused");
  a_ignore_keeps_on: assert property (
    resp == 2'h0 && o_output_enable && run_ok && !i_cmd_wr |=>
    o_output_enable)
    else $error("output dropped while fault ignored");
  a_delay_keeps_on: assert property (
    s_fault_on(2'h1) && o_output_enable && run_ok |=>
    o_output_enable [*2])
    else $error("output dropped during delay");
  a_disable_fast: assert property (
    s_fault_on(2'h2) |-> ##[0:2] !o_output_enable)
    else $error("output not disabled at once");
  a_latch_stays_off: assert property (
    o_latched_off ##1 o_latched_off |-> !o_output_enable)
    else $error("output on while latched");
  a_latch_holds: assert property (
    o_latched_off && i_on_cmd && i_bias_ok && !i_clear_faults &&
    !i_clear_uv_fault_bit |=> o_latched_off)
    else $error("latched state left without a clear");
  a_retry_limit: assert property (
    act_r[5:3] != 3'h7 |-> o_retry_count <= act_r[5:3])
    else $error("retry count above setting");
  a_off_clears: assert property (
    !i_on_cmd [*3] |-> o_retry_count == 3'h0 && !o_output_enable)
    else $error("off command left count or output");
  a_ratio_gated: assert property (
    !i_ratio_regulation_en [*2] |-> !o_ratio_regulation_active)
    else $error("ratio regulation active while disabled");
endmodule
bind ivf_input_voltage_fault ivf_monitor i_mon (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_cmd_wr(i_cmd_wr),
  .i_cmd_rd(i_cmd_rd),
  .i_cmd_code(i_cmd_code),
  .i_cmd_wdata(i_cmd_wdata),
  .o_cmd_rdata(o_cmd_rdata),
  .o_cmd_ack(o_cmd_ack),
  .o_cmd_nack(o_cmd_nack),
  .i_on_cmd(i_on_cmd),
  .i_bias_ok(i_bias_ok),
  .i_clear_faults(i_clear_faults),
  .i_clear_uv_fault_bit(i_clear_uv_fault_bit),
  .i_other_shutdown(i_other_shutdown),
  .i_ratio_regulation_en(i_ratio_regulation_en),
  .o_output_enable(o_output_enable),
  .o_vin_uv_fault(o_vin_uv_fault),
  .o_ratio_regulation_active(o_ratio_regulation_active),
  .o_latched_off(o_latched_off),
  .o_retry_count(o_retry_count)
);
`default_nettype wire

// *** verification/ivf_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ivf_host_model (
  // clock
  input wire logic i_clk,
  // answer from device
  input wire logic [15:0] i_cmd_rdata,
  input wire logic i_cmd_ack,
  input wire logic i_cmd_nack,
  // request to device
  output logic o_cmd_wr,
  output logic o_cmd_rd,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_wdata
);
  // idle bus at start
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_wdata = 16'h0000;
  end
  // one command, answer taken one cycle after the strobe
  task automatic xfer(input logic rd, input logic [7:0] code,
    input logic [15:0] wd, output logic [15:0] d, output logic ok);
    @(negedge i_clk);
    o_cmd_rd = rd;
    o_cmd_wr = !rd;
    o_cmd_code = code;
    o_cmd_wdata = wd;
    @(negedge i_clk);
    o_cmd_rd = 1'b0;
    o_cmd_wr = 1'b0;
    o_cmd_wdata = ~wd; // released data no longer valid
    d = i_cmd_rdata;
    ok = i_cmd_ack && !i_cmd_nack;
  endtask
endmodule
`default_nettype wire

// *** verification/ivf_input_voltage_fault_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module ivf_input_voltage_fault_tb;
  localparam int P_MS = 4;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_cmd_wr, i_cmd_rd, o_cmd_ack, o_cmd_nack;
  logic [7:0] i_cmd_code;
  logic [15:0] i_cmd_wdata, o_cmd_rdata;
  logic [15:0] i_vin_linear = 16'h0030;
  logic i_vin_valid = 1'b1;
  logic i_on_cmd = 1'b1;
  logic i_bias_ok = 1'b1;
  logic i_clear_faults = 1'b0;
  logic i_clear_uv_fault_bit = 1'b0;
  logic i_other_shutdown = 1'b0;
  logic i_ratio_regulation_en = 1'b0;
  logic [7:0] i_time_unit_ms = 8'h01;
  logic o_output_enable, o_vin_ov_warn, o_vin_uv_warn, o_vin_uv_fault;
  logic o_ratio_regulation_active, o_latched_off;
  logic [2:0] o_retry_count;
  int errors = 0;
  int total_checks = 0;

  // ----
  // clock, design and host
  // ----
  always #50 i_clk = ~i_clk;
  ivf_input_voltage_fault #(.P_MS_CYCLES(P_MS)) i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_wr(i_cmd_wr),
    .i_cmd_rd(i_cmd_rd), .i_cmd_code(i_cmd_code), .i_cmd_wdata(i_cmd_wdata),
    .o_cmd_rdata(o_cmd_rdata), .o_cmd_ack(o_cmd_ack),
    .o_cmd_nack(o_cmd_nack), .i_vin_linear(i_vin_linear),
    .i_vin_valid(i_vin_valid), .i_on_cmd(i_on_cmd), .i_bias_ok(i_bias_ok),
    .i_clear_faults(i_clear_faults),
    .i_clear_uv_fault_bit(i_clear_uv_fault_bit),
    .i_other_shutdown(i_other_shutdown),
    .i_ratio_regulation_en(i_ratio_regulation_en),
    .i_time_unit_ms(i_time_unit_ms), .o_output_enable(o_output_enable),
    .o_vin_ov_warn(o_vin_ov_warn), .o_vin_uv_warn(o_vin_uv_warn),
    .o_vin_uv_fault(o_vin_uv_fault),
    .o_ratio_regulation_active(o_ratio_regulation_active),
    .o_latched_off(o_latched_off), .o_retry_count(o_retry_count));
  ivf_host_model i_host (.i_clk(i_clk), .i_cmd_rdata(o_cmd_rdata),
    .i_cmd_ack(o_cmd_ack), .i_cmd_nack(o_cmd_nack), .o_cmd_wr(i_cmd_wr),
    .o_cmd_rd(i_cmd_rd), .o_cmd_code(i_cmd_code), .o_cmd_wdata(i_cmd_wdata));

  // ----
  // helpers
  // ----
  task automatic complete_run;
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic cmd(input logic rd, input logic [7:0] c,
    input logic [15:0] wd, input logic [15:0] exp, input logic ok_exp);
    logic [15:0] d;
    logic ok;
    i_host.xfer(rd, c, wd, d, ok);
    check(ok === ok_exp && (!rd || d === exp), "command answer");
  endtask
  task automatic act(input logic [7:0] b);
    i_on_cmd = 1'b0;
    cyc(3);
    cmd(0, ivf_pkg::CMD_VIN_UV_ACTION, {8'h00, b}, 16'h0000, 1'b1);
    i_on_cmd = 1'b1;
    cyc(4);
  endtask
  task automatic clr;
    cyc(2); // restored sample reaches the compare before the clear
    i_clear_faults = 1'b1;
    cyc(1);
    i_clear_faults = 1'b0;
    cyc(2);
  endtask
  task automatic wait_latch(output int n);
    n = 0;
    while (o_latched_off !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    for (int k = 0; k < 4; k++) begin
      cmd(1, ivf_pkg::CMD_VIN_OV_WARN + 8'(k), 16'h0, 16'h0, 1'b1);
    end
    cmd(0, ivf_pkg::CMD_VIN_OV_WARN, 16'h004b, 16'h0, 1'b1);
    cmd(0, ivf_pkg::CMD_VIN_UV_WARN, 16'h0028, 16'h0, 1'b1);
    cmd(0, ivf_pkg::CMD_VIN_UV_FAULT, 16'h0024, 16'h0, 1'b1);
    cmd(0, ivf_pkg::CMD_VIN_UV_ACTION, 16'hff00, 16'h0, 1'b1);
    cmd(1, ivf_pkg::CMD_VIN_OV_WARN, 16'h0, 16'h004b, 1'b1);
    cmd(1, ivf_pkg::CMD_VIN_UV_WARN, 16'h0, 16'h0028, 1'b1);
    cmd(1, ivf_pkg::CMD_VIN_UV_FAULT, 16'h0, 16'h0024, 1'b1);
    cmd(1, ivf_pkg::CMD_VIN_UV_ACTION, 16'h0, 16'h0000, 1'b1);
    cmd(1, 8'h5b, 16'h0, 16'h0000, 1'b0);
  endtask
  task automatic t_ratio;
    i_ratio_regulation_en = 1'b1;
    cyc(3);
    check(o_ratio_regulation_active === 1'b1, "ratio on");
    i_vin_linear = 16'h0026;
    cyc(3);
    check(o_vin_uv_warn === 1'b1, "below warn");
    check(o_ratio_regulation_active === 1'b0, "ratio below");
    i_vin_linear = 16'h0050;
    cyc(3);
    check(o_vin_ov_warn === 1'b1, "over warn");
    i_ratio_regulation_en = 1'b0;
    cyc(3);
    check(o_ratio_regulation_active === 1'b0, "ratio gated");
    i_vin_linear = 16'h0030;
  endtask
  task automatic t_ignore;
    i_vin_linear = 16'h0020;
    cyc(40);
    check(o_output_enable && o_vin_uv_fault, "ignored fault");
    i_vin_linear = 16'h0030;
    clr();
    check(o_vin_uv_fault === 1'b0, "flag cleared");
  endtask
  task automatic t_delay_on;
    int n;
    act(8'h4a);
    i_vin_linear = 16'h0020;
    cyc(12);
    check(o_output_enable === 1'b1, "runs during delay");
    wait_latch(n);
    check(n < 60 && o_output_enable === 1'b0, "off after delay");
    i_vin_linear = 16'h0030;
    clr();
  endtask
  task automatic t_retry;
    int n, d, u, e;
    for (int r = 0; r < 7; r++) begin
      d = r % 3;
      u = 1 + r / 4;
      i_time_unit_ms = 8'(u);
      act({2'b10, 3'(r), 3'(d)});
      i_vin_linear = 16'h0020;
      wait_latch(n);
      e = (r << d) * u * P_MS;
      check(n >= e && n <= e + 4 * r + 8, "retry spacing");
      check(o_retry_count === 3'(r), "retries");
      check(o_output_enable === 1'b0, "off after tries");
      i_vin_linear = 16'h0030;
      cyc(3);
      check(o_latched_off === 1'b1, "stays latched");
      clr();
      cyc(3);
      check(o_output_enable && o_retry_count === 3'h0, "restart");
    end
    i_time_unit_ms = 8'h01;
  endtask
  task automatic t_latch;
    act(8'hc0);
    for (int m = 0; m < 4; m++) begin
      i_vin_linear = 16'h0020;
      cyc(6);
      check(o_latched_off && !o_output_enable, "latched");
      i_vin_linear = 16'h0030;
      cyc(3);
      case (m)
        0: i_clear_faults = 1'b1;
        1: i_clear_uv_fault_bit = 1'b1;
        2: i_on_cmd = 1'b0;
        default: i_bias_ok = 1'b0;
      endcase
      cyc(1);
      {i_clear_faults, i_clear_uv_fault_bit, i_on_cmd, i_bias_ok} = 4'h3;
      cyc(5);
      check(o_output_enable && !o_latched_off, "cleared");
    end
  endtask
  task automatic t_forever;
    act(8'hb8);
    i_vin_linear = 16'h0020;
    cyc(60);
    check(o_latched_off === 1'b0, "keeps retrying");
    i_other_shutdown = 1'b1;
    cyc(2);
    check(o_latched_off && !o_output_enable, "other shutdown");
    i_other_shutdown = 1'b0;
    i_on_cmd = 1'b0;
    cyc(4);
    check(!o_output_enable && o_retry_count === 3'h0, "off stops");
    i_vin_linear = 16'h0030;
    i_on_cmd = 1'b1;
    cyc(4);
  endtask

  // ----
  // main sequence and watchdog
  // ----
  initial begin
    cyc(5);
    i_reset_n = 1'b1;
    t_regs();
    t_ratio();
    t_ignore();
    t_delay_on();
    t_retry();
    t_latch();
    t_forever();
    complete_run();
  end
  initial begin
    #2_000_000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
